// File: bench/qss_host.sv
`timescale 1ns/1ns
module qss_host (
  input wire logic clk,
  output qss_pkg::qss_cmd_type cmd
);
  initial cmd = '0;
  task automatic issue(input logic [2:0] op, input qss_pkg::qss_sel_type sel, input logic [31:0] data);
    @(posedge clk) #1 cmd = {op, sel, data};
    @(posedge clk) #1 cmd = '0;
  endtask : issue
endmodule : qss_host

// File: bench/qss_props.sv
`timescale 1ns/1ns
module qss_props (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire qss_pkg::qss_cmd_type CMD,
  input wire qss_pkg::qss_resp_type RESP,
  input wire logic QUESTIONABLE_SUMMARY_FLAG,
  input wire logic INSTRUMENT_SUMMARY_FLAG
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  wire take = CE && CMD.rd && CMD.sel != qss_pkg::QSS_SEL_NONE;
  wire pre = CE && CMD.preset;
  wire qm = CE && CMD.sel == qss_pkg::QSS_SEL_QUES_MASK;
  // Nothing that may lower the questionable flag
  wire calm = !(CMD.rd && CMD.sel == qss_pkg::QSS_SEL_QUES_EVENT) && !CMD.wr && !CMD.preset;
  wire flags = QUESTIONABLE_SUMMARY_FLAG || INSTRUMENT_SUMMARY_FLAG;
  AST_ANSWER: assert property (take |=> RESP.valid) else $error("no answer");
  AST_QUIET: assert property (CE && !take |=> !RESP.valid) else $error("stray answer");
  AST_DIGIT: assert property (RESP.valid |-> RESP.value % 16'ha == 16'(RESP.decimal[3:0]))
    else $error("bad digit");
  AST_POWER: assert property (disable iff (1'h0) !RESETN |=> !flags) else $error("flag after reset");
  AST_PRESET: assert property (pre ##1 !CMD.wr ##1 qm && CMD.rd |=> RESP.value == 16'h0)
    else $error("mask kept");
  AST_CLEAR: assert property (pre ##1 !CMD.wr |=> !flags) else $error("flag kept");
  AST_STORE: assert property (qm && CMD.wr && !pre ##1 calm ##1 qm && CMD.rd
    |=> RESP.value == $past(CMD.wdata[15:0], 3)) else $error("mask lost");
  AST_LATCH: assert property (QUESTIONABLE_SUMMARY_FLAG && calm && $past(calm) |=> QUESTIONABLE_SUMMARY_FLAG)
    else $error("flag dropped");
endmodule : qss_props
bind qss_status_summary qss_props chk (
  .CLK(CLK), .RESETN(RESETN), .CE(CE), .CMD(CMD), .RESP(RESP),
  .QUESTIONABLE_SUMMARY_FLAG(QUESTIONABLE_SUMMARY_FLAG), .INSTRUMENT_SUMMARY_FLAG(INSTRUMENT_SUMMARY_FLAG));

// File: bench/qss_status_summary_test.sv
`timescale 1ns/1ns
module qss_status_summary_test;
  logic clk = 1'h0, resetn = 1'h0, ce = 1'h1, qflag, iflag;
  logic [15:0] qsrc = '0, isrc = '0;
  qss_pkg::qss_cmd_type cmd;
  qss_pkg::qss_resp_type resp;
  int mismatches = 0, comparisons = 0;
  qss_status_summary dut (.CLK(clk), .RESETN(resetn), .CE(ce), .QUES_SOURCE(qsrc), .INST_SOURCE(isrc),
    .CMD(cmd), .RESP(resp), .QUESTIONABLE_SUMMARY_FLAG(qflag), .INSTRUMENT_SUMMARY_FLAG(iflag));
  qss_host host (.clk(clk), .cmd(cmd));
  initial forever #5 clk = ~clk;
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Answer must be flagged valid and carry the expected value
  task automatic rd(input qss_pkg::qss_sel_type sel, input logic [15:0] exp);
    host.issue(3'h4, sel, 32'h0);
    check({resp.valid, 3'h0, resp.value}, {4'h8, exp});
  endtask : rd
  // Long enough to pass the synchronisers and latch
  task automatic hold(input logic [15:0] q, input logic [15:0] i);
    {qsrc, isrc} = {q, i};
    #50;
  endtask : hold
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    #20000 mismatches++;
    wrap_up();
  end
  initial begin
    #16 resetn = 1'h1;
    rd(qss_pkg::QSS_SEL_QUES_MASK, 16'h0);
    rd(qss_pkg::QSS_SEL_INST_MASK, 16'h0);
    host.issue(3'h2, qss_pkg::QSS_SEL_QUES_MASK, 32'h1_2000);
    rd(qss_pkg::QSS_SEL_QUES_MASK, 16'h2000);
    check(resp.decimal, 20'h08192);
    // A write while the clock enable is low must be lost
    ce = 1'h0;
    host.issue(3'h2, qss_pkg::QSS_SEL_QUES_MASK, 32'h00ff);
    ce = 1'h1;
    rd(qss_pkg::QSS_SEL_QUES_MASK, 16'h2000);
    hold(16'h2004, 16'h0);
    check({19'h0, qflag}, 20'h1);
    hold(16'h0, 16'h0);
    rd(qss_pkg::QSS_SEL_QUES_EVENT, 16'h2004);
    check(resp.decimal, 20'h08196);
    rd(qss_pkg::QSS_SEL_QUES_EVENT, 16'h0);
    host.issue(3'h2, qss_pkg::QSS_SEL_INST_MASK, 32'h2);
    rd(qss_pkg::QSS_SEL_INST_MASK, 16'h0002);
    hold(16'h0, 16'h0006);
    check({18'h0, iflag, qflag}, 20'h2);
    hold(16'h0, 16'h0);
    rd(qss_pkg::QSS_SEL_INST_EVENT, 16'h0006);
    rd(qss_pkg::QSS_SEL_QUES_EVENT, 16'h0002);
    hold(16'h0010, 16'h0);
    hold(16'h0, 16'h0);
    host.issue(3'h1, qss_pkg::QSS_SEL_NONE, 32'h0);
    rd(qss_pkg::QSS_SEL_QUES_MASK, 16'h0);
    rd(qss_pkg::QSS_SEL_INST_MASK, 16'h0);
    rd(qss_pkg::QSS_SEL_QUES_EVENT, 16'h0010);
    // Second reset in mid-run must zero a written mask again
    host.issue(3'h2, qss_pkg::QSS_SEL_INST_MASK, 32'hffff);
    resetn = 1'h0;
    repeat (2) @(posedge clk);
    #1 resetn = 1'h1;
    rd(qss_pkg::QSS_SEL_INST_MASK, 16'h0);
    check({18'h0, iflag, qflag}, 20'h0);
    wrap_up();
  end
endmodule : qss_status_summary_test

// File: hdl/qss_status_summary.sv
`timescale 1ns/1ns
module qss_status_summary (
  input  wire logic                              CLK,
  input  wire logic                              RESETN,
  input  wire logic                              CE,
  input  wire logic [qss_pkg::REG_W-1:0]         QUES_SOURCE,
  input  wire logic [qss_pkg::REG_W-1:0]         INST_SOURCE,
  input  wire qss_pkg::qss_cmd_type              CMD,
  output qss_pkg::qss_resp_type                  RESP,
  output logic                                   QUESTIONABLE_SUMMARY_FLAG,
  output logic                                   INSTRUMENT_SUMMARY_FLAG
);

  logic [qss_pkg::REG_W-1:0] ques_src_sync;
  logic [qss_pkg::REG_W-1:0] inst_src_sync;
  logic [qss_pkg::REG_W-1:0] ques_set;
  logic [qss_pkg::REG_W-1:0] ques_event;
  logic [qss_pkg::REG_W-1:0] ques_mask;
  logic [qss_pkg::REG_W-1:0] inst_event;
  logic [qss_pkg::REG_W-1:0] inst_mask;
  logic [qss_pkg::REG_W-1:0] read_value;
  logic [qss_pkg::REG_W-1:0] load_value;
  logic                      ques_clear;
  logic                      inst_clear;
  logic                      ques_load;
  logic                      inst_load;
  logic                      ques_hit_next;
  logic                      inst_hit;
  logic                      inst_hit_next;
  qss_pkg::qss_resp_type     resp_reg;
  qss_pkg::qss_resp_type     resp_next;
  logic                      qsum_reg;
  logic                      qsum_next;
  logic                      instrument_summary_flag_reg;
  logic                      instrument_summary_flag_next;

  // Binary to packed BCD by shift-and-add
  function automatic logic [qss_pkg::DEC_W-1:0] to_decimal(input logic [qss_pkg::REG_W-1:0] bin);
    logic [qss_pkg::DEC_W-1:0] bcd;
    bcd = '0;
    for (int i = qss_pkg::REG_W - 1; i >= 0; i--) begin
      for (int d = 0; d < qss_pkg::DEC_DIGITS; d++) begin
        if (bcd[d*4 +: 4] > 4'h4) begin
          bcd[d*4 +: 4] = bcd[d*4 +: 4] + 4'h3;
        end
      end
      bcd = {bcd[qss_pkg::DEC_W-2:0], bin[i]};
    end
    return bcd;
  endfunction : to_decimal

  // Sources come from outside; two flops before use
  qss_sync2 #(
    .WIDTH(qss_pkg::REG_W)
  ) ques_sync (
    .clk     (CLK),
    .resetn  (RESETN),
    .ce      (CE),
    .async_in(QUES_SOURCE),
    .sync_out(ques_src_sync)
  );

  qss_sync2 #(
    .WIDTH(qss_pkg::REG_W)
  ) inst_sync (
    .clk     (CLK),
    .resetn  (RESETN),
    .ce      (CE),
    .async_in(INST_SOURCE),
    .sync_out(inst_src_sync)
  );

  always_comb begin
    ques_set = ques_src_sync;
    ques_set[qss_pkg::INSTR_SUMMARY_BIT] = inst_hit;
    ques_clear = CMD.rd && CMD.sel == qss_pkg::QSS_SEL_QUES_EVENT;
    inst_clear = CMD.rd && CMD.sel == qss_pkg::QSS_SEL_INST_EVENT;
    ques_load  = CMD.wr && CMD.sel == qss_pkg::QSS_SEL_QUES_MASK;
    inst_load  = CMD.wr && CMD.sel == qss_pkg::QSS_SEL_INST_MASK;
    load_value = CMD.wdata[qss_pkg::REG_W-1:0];
    read_value = '0;
    unique case (CMD.sel)
      qss_pkg::QSS_SEL_QUES_EVENT: read_value = ques_event;
      qss_pkg::QSS_SEL_QUES_MASK:  read_value = ques_mask;
      qss_pkg::QSS_SEL_INST_EVENT: read_value = inst_event;
      qss_pkg::QSS_SEL_INST_MASK:  read_value = inst_mask;
      default:                     read_value = '0;
    endcase
    resp_next.valid   = CMD.rd && CMD.sel != qss_pkg::QSS_SEL_NONE;
    resp_next.value   = resp_next.valid ? read_value : resp_reg.value;
    resp_next.decimal = resp_next.valid ? to_decimal(read_value) : resp_reg.decimal;
    qsum_next = ques_hit_next;
    instrument_summary_flag_next = inst_hit_next;
  end

  qss_status_bank #(
    .WIDTH(qss_pkg::REG_W)
  ) ques_bank (
    .clk       (CLK),
    .resetn    (RESETN),
    .ce        (CE),
    .set_bits  (ques_set),
    .clear     (ques_clear),
    .load      (ques_load),
    .load_value(load_value),
    .preset    (CMD.preset),
    .event_bits(ques_event),
    .mask_bits (ques_mask),
    .hit       (),
    .hit_next  (ques_hit_next)
  );

  qss_status_bank #(
    .WIDTH(qss_pkg::REG_W)
  ) inst_bank (
    .clk       (CLK),
    .resetn    (RESETN),
    .ce        (CE),
    .set_bits  (inst_src_sync),
    .clear     (inst_clear),
    .load      (inst_load),
    .load_value(load_value),
    .preset    (CMD.preset),
    .event_bits(inst_event),
    .mask_bits (inst_mask),
    .hit       (inst_hit),
    .hit_next  (inst_hit_next)
  );

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      resp_reg <= '0;
      qsum_reg <= 1'h0;
      instrument_summary_flag_reg <= 1'h0;
    end else if (CE) begin
      resp_reg <= resp_next;
      qsum_reg <= qsum_next;
      instrument_summary_flag_reg <= instrument_summary_flag_next;
    end
  end

  always_comb begin
    RESP                      = resp_reg;
    QUESTIONABLE_SUMMARY_FLAG = qsum_reg;
    INSTRUMENT_SUMMARY_FLAG   = instrument_summary_flag_reg;
  end

endmodule : qss_status_summary

// Two-flop synchroniser for level inputs from another domain
module qss_sync2 #(
  parameter int unsigned WIDTH = qss_pkg::REG_W
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage1_next;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage2_next;

  always_comb begin
    stage1_next = async_in;
    stage2_next = stage1_reg;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      stage1_reg <= WIDTH'(qss_pkg::EVENT_RESET);
      stage2_reg <= WIDTH'(qss_pkg::EVENT_RESET);
    end else if (ce) begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  // Only the second stage is visible to the logic
  always_comb begin
    sync_out = stage2_reg;
  end

endmodule : qss_sync2

// One event register with its enable mask and roll-up
module qss_status_bank #(
  parameter int unsigned WIDTH = qss_pkg::REG_W
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] set_bits,
  input  wire logic             clear,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  input  wire logic             preset,
  output logic      [WIDTH-1:0] event_bits,
  output logic      [WIDTH-1:0] mask_bits,
  output logic                  hit,
  output logic                  hit_next
);

  logic [WIDTH-1:0] event_reg;
  logic [WIDTH-1:0] event_next;
  logic [WIDTH-1:0] mask_reg;
  logic [WIDTH-1:0] mask_next;

  always_comb begin
    event_next = event_reg;
    mask_next  = mask_reg;
    if (clear) begin
      event_next = '0;
    end
    // New events win over a clearing read in the same cycle
    event_next = event_next | set_bits;
    if (load) begin
      mask_next = load_value;
    end
    // Preset touches the mask only, never the events
    if (preset) begin
      mask_next = WIDTH'(qss_pkg::MASK_RESET);
    end
    hit      = |(event_reg & mask_reg);
    hit_next = |(event_next & mask_next);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      event_reg <= WIDTH'(qss_pkg::EVENT_RESET);
      mask_reg  <= WIDTH'(qss_pkg::MASK_RESET);
    end else if (ce) begin
      event_reg <= event_next;
      mask_reg  <= mask_next;
    end
  end

  always_comb begin
    event_bits = event_reg;
    mask_bits  = mask_reg;
  end

endmodule : qss_status_bank

// File: include/qss_pkg.sv
package qss_pkg;

  localparam int unsigned REG_W = 16;

  localparam logic [REG_W-1:0] MASK_RESET = 16'h0000;
  localparam logic [REG_W-1:0] EVENT_RESET = 16'h0000;

  // Position of the instrument summary flag inside the questionable event register
  localparam int unsigned INSTR_SUMMARY_BIT = 1;

  // Width of the decimal answer: five digits cover 0..65535
  localparam int unsigned DEC_DIGITS = 5;
  localparam int unsigned DEC_W = DEC_DIGITS * 4;

  typedef enum logic [2:0] {
    QSS_SEL_QUES_EVENT,
    QSS_SEL_QUES_MASK,
    QSS_SEL_INST_EVENT,
    QSS_SEL_INST_MASK,
    QSS_SEL_NONE
  } qss_sel_type;

  typedef struct packed {
    logic             rd;
    logic             wr;
    logic             preset;
    qss_sel_type      sel;
    logic [31:0]      wdata;
  } qss_cmd_type;

  typedef struct packed {
    logic             valid;
    logic [REG_W-1:0] value;
    logic [DEC_W-1:0] decimal;
  } qss_resp_type;

endpackage : qss_pkg
